//--- logic/mcic_pkg.sv
// Package: register map, field layout and reset values of the interrupt control block
package mcic_pkg;

   // ======================================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] ADDR_CTRL       = 8'h00;
   localparam logic [7:0] ADDR_MOT_MASK0  = 8'h04;
   localparam logic [7:0] ADDR_MOT_MASK1  = 8'h08;
   localparam logic [7:0] ADDR_IN_MASK    = 8'h0c;
   localparam logic [7:0] ADDR_MOT_STAT0  = 8'h10;
   localparam logic [7:0] ADDR_MOT_STAT1  = 8'h14;
   localparam logic [7:0] ADDR_IN_STAT    = 8'h18;
   localparam logic [7:0] ADDR_ERR_STAT   = 8'h1c;
   localparam logic [7:0] ADDR_ERR_CODE0  = 8'h20;
   localparam logic [7:0] ADDR_ERR_CODE1  = 8'h24;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h28;
   localparam logic [7:0] ADDR_IRQ_MASK   = 8'h2c;

   // ======================================================================
   // Field layout
   localparam int          NUM_AXES        = 2;
   localparam int          NUM_DIN         = 4;
   localparam logic [31:0] MOT_VALID_BITS  = 32'h0009_fff7;
   localparam logic [15:0] IN_VALID_BITS   = 16'h87ff;
   localparam int          IN_SEL_EDGE_BIT = 10;
   localparam int          IN_SWITCH_BIT   = 15;
   localparam int          IN_SEL_X_BIT    = 8;
   localparam int          IN_SEL_Y_BIT    = 9;
   localparam int          CTRL_GIE_BIT    = 0;
   localparam int          ERR_CODE_W      = 5;
   localparam int          IRQ_W           = 3;
   localparam int          IRQ_MOT_BIT     = 0;
   localparam int          IRQ_IN_BIT      = 1;
   localparam int          IRQ_ERR_BIT     = 2;

   // ======================================================================
   // Error codes reported per axis; all but the encoder and pulse faults stop the axis
   localparam logic [4:0] ERR_SOFT_POS    = 5'h00;
   localparam logic [4:0] ERR_SOFT_NEG    = 5'h01;
   localparam logic [4:0] ERR_CMP3        = 5'h02;
   localparam logic [4:0] ERR_CMP4        = 5'h03;
   localparam logic [4:0] ERR_CMP5        = 5'h04;
   localparam logic [4:0] ERR_END_POS     = 5'h05;
   localparam logic [4:0] ERR_END_NEG     = 5'h06;
   localparam logic [4:0] ERR_ALARM       = 5'h07;
   localparam logic [4:0] ERR_SYNC_STOP   = 5'h08;
   localparam logic [4:0] ERR_EMERGENCY   = 5'h09;
   localparam logic [4:0] ERR_SLOW_DOWN   = 5'h0a;
   localparam logic [4:0] ERR_INTERP_OP   = 5'h0c;
   localparam logic [4:0] ERR_OTHER_AXIS  = 5'h0d;
   localparam logic [4:0] ERR_PLS_BUF_OVF = 5'h0e;
   localparam logic [4:0] ERR_INTERP_OVF  = 5'h0f;
   localparam logic [4:0] ERR_ENC_FAULT   = 5'h10;
   localparam logic [4:0] ERR_PLS_FAULT   = 5'h11;
   localparam int         ERR_SRC_W       = 18;
   localparam logic [17:0] ERR_NOSTOP_SRCS = 18'h3_0000;

   // ======================================================================
   // Reset values
   localparam logic [31:0] MOT_MASK_RST  = 32'h0000_0000;
   localparam logic [15:0] IN_MASK_RST   = 16'h8000;
   localparam logic [2:0]  IRQ_MASK_RST  = 3'h7;
   localparam logic [4:0]  ERR_CODE_RST  = 5'h00;

   typedef enum logic [2:0] {
      EDGE_IDLE  = 3'b001,
      EDGE_ARMED = 3'b010,
      EDGE_HOLD  = 3'b100
   } sync_state_t;

endpackage

//--- logic/input_sync.sv
// Two-stage synchroniser with edge detection for asynchronous inputs
`timescale 1ns/1ps
module input_sync
   import mcic_pkg::*;
#(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             srst_i,
   // Raw and conditioned signals
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] level_o,
   output logic      [WIDTH-1:0] rise_o,
   output logic      [WIDTH-1:0] fall_o
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] prev_reg;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         meta_reg <= '0;
         sync_reg <= '0;
         prev_reg <= '0;
      end else begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   assign level_o = sync_reg;
   assign rise_o  = sync_reg & ~prev_reg;
   assign fall_o  = ~sync_reg & prev_reg;

endmodule

//--- logic/motion_card_interrupt_control.sv
// Interrupt control: motion, card input and error event collection for a two-axis card
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
module motion_card_interrupt_control
   import mcic_pkg::*;
(
   // Clock and reset
   input  wire logic                      clk_i,
   input  wire logic                      srst_i,
   // Register port
   input  wire logic [7:0]                addr_i,
   input  wire logic [31:0]               wdata_i,
   input  wire logic                      wr_i,
   input  wire logic                      rd_i,
   output logic      [31:0]               rdata_o,
   // Motion events from axis logic, one pulse per event
   input  wire logic [31:0]               motion_event_ax0_i,
   input  wire logic [31:0]               motion_event_ax1_i,
   // Error stop sources per axis, one pulse per event, index is the code
   input  wire logic [ERR_SRC_W-1:0]      error_event_ax0_i,
   input  wire logic [ERR_SRC_W-1:0]      error_event_ax1_i,
   // Card input pins
   input  wire logic [NUM_DIN-1:0]        digital_input_i,
   input  wire logic                      selectable_input_x_i,
   input  wire logic                      selectable_input_y_i,
   // Axis stop requests and interrupt request
   output logic      [NUM_AXES-1:0]       axis_stop_o,
   output logic                           irq_o
);

   // ======================================================================
   // Registers
   logic                                  gie_reg;
   logic [31:0]                           mot_mask_reg [NUM_AXES];
   logic [15:0]                           in_mask_reg;
   logic [31:0]                           mot_stat_reg [NUM_AXES];
   logic [15:0]                           in_stat_reg;
   logic [NUM_AXES-1:0]                   err_stat_reg;
   logic [ERR_CODE_W-1:0]                 err_code_reg [NUM_AXES];
   logic [IRQ_W-1:0]                      irq_stat_reg;
   logic [IRQ_W-1:0]                      irq_mask_reg;
   logic [NUM_AXES-1:0]                   axis_stop_reg;
   logic [31:0]                           rdata_reg;
   logic [31:0]                           mot_evt [NUM_AXES];
   logic [ERR_SRC_W-1:0]                  err_evt [NUM_AXES];

   assign mot_evt[0] = motion_event_ax0_i;
   assign mot_evt[1] = motion_event_ax1_i;
   assign err_evt[0] = error_event_ax0_i;
   assign err_evt[1] = error_event_ax1_i;

   // ======================================================================
   // Pin synchronisers
   logic [NUM_DIN+1:0]                    pin_rise;
   logic [NUM_DIN+1:0]                    pin_fall;

   input_sync #(
      .WIDTH   (NUM_DIN + 2)
   ) u_pins (
      .clk_i   (clk_i),
      .srst_i  (srst_i),
      .async_i ({selectable_input_y_i, selectable_input_x_i, digital_input_i}),
      .level_o (),
      .rise_o  (pin_rise),
      .fall_o  (pin_fall)
   );

   // ======================================================================
   // Card input events
   logic [15:0]                           in_evt;
   logic                                  sel_edge;

   always_comb begin
      sel_edge = in_mask_reg[IN_SEL_EDGE_BIT];
      in_evt = 16'h0000;
      in_evt[NUM_DIN-1:0]         = pin_fall[NUM_DIN-1:0];
      in_evt[2*NUM_DIN-1:NUM_DIN] = pin_rise[NUM_DIN-1:0];
      in_evt[IN_SEL_X_BIT] = sel_edge ? pin_rise[NUM_DIN] : pin_fall[NUM_DIN];
      in_evt[IN_SEL_Y_BIT] = sel_edge ? pin_rise[NUM_DIN+1] : pin_fall[NUM_DIN+1];
      // Master switch gates every input event
      in_evt = in_evt & in_mask_reg & IN_VALID_BITS
               & {16{in_mask_reg[IN_SWITCH_BIT]}};
      in_evt[IN_SWITCH_BIT] = 1'b0;
      in_evt[IN_SEL_EDGE_BIT] = 1'b0;
   end

   // ======================================================================
   // Register decode
   logic wr_ctrl;
   logic wr_in_mask;
   logic wr_in_stat;
   logic wr_err_stat;
   logic wr_irq_stat;
   logic wr_irq_mask;
   assign wr_ctrl     = wr_i && (addr_i == ADDR_CTRL);
   assign wr_in_mask  = wr_i && (addr_i == ADDR_IN_MASK);
   assign wr_in_stat  = wr_i && (addr_i == ADDR_IN_STAT);
   assign wr_err_stat = wr_i && (addr_i == ADDR_ERR_STAT);
   assign wr_irq_stat = wr_i && (addr_i == ADDR_IRQ_STATUS);
   assign wr_irq_mask = wr_i && (addr_i == ADDR_IRQ_MASK);

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         gie_reg <= 1'b0;
      end else if (wr_ctrl) begin
         gie_reg <= wdata_i[CTRL_GIE_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         in_mask_reg <= IN_MASK_RST;
      end else if (wr_in_mask) begin
         // Switch bit forced high, unused bits kept zero
         in_mask_reg <= (wdata_i[15:0] & IN_VALID_BITS) | IN_MASK_RST;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         in_stat_reg <= 16'h0000;
      end else begin
         // New event wins over write-one-to-clear
         in_stat_reg <= (in_stat_reg & ~(wr_in_stat ? wdata_i[15:0] : 16'h0000))
                        | in_evt;
      end
   end

   // ======================================================================
   // Per-axis motion and error logic
   logic [NUM_AXES-1:0] mot_pend;

   genvar g;
   generate
      for (g = 0; g < NUM_AXES; g++) begin : g_axis
         logic                  wr_mask_ax;
         logic                  wr_stat_ax;
         logic [ERR_CODE_W-1:0] code_sel;
         logic                  any_err;
         logic                  stop_err;

         assign wr_mask_ax = wr_i && (addr_i == ADDR_MOT_MASK0 + 8'(4 * g));
         assign wr_stat_ax = wr_i && (addr_i == ADDR_MOT_STAT0 + 8'(4 * g));

         always_ff @(posedge clk_i) begin
            if (srst_i) begin
               mot_mask_reg[g] <= MOT_MASK_RST;
            end else if (wr_mask_ax) begin
               mot_mask_reg[g] <= wdata_i & MOT_VALID_BITS;
            end
         end

         always_ff @(posedge clk_i) begin
            if (srst_i) begin
               mot_stat_reg[g] <= 32'h0000_0000;
            end else begin
               mot_stat_reg[g] <= (mot_stat_reg[g] & ~(wr_stat_ax ? wdata_i : 32'h0))
                                  | (mot_evt[g] & mot_mask_reg[g]);
            end
         end

         assign mot_pend[g] = |mot_stat_reg[g];

         // Highest-numbered simultaneous error source gives the code
         always_comb begin
            code_sel = ERR_CODE_RST;
            for (int k = 0; k < ERR_SRC_W; k++) begin
               if (err_evt[g][k] && (k != 11)) begin
                  code_sel = ERR_CODE_W'(k);
               end
            end
         end

         assign any_err  = |(err_evt[g] & ~ERR_SRC_W'(1 << 11));
         assign stop_err = |(err_evt[g] & ~ERR_NOSTOP_SRCS & ~ERR_SRC_W'(1 << 11));

         always_ff @(posedge clk_i) begin
            if (srst_i) begin
               err_code_reg[g] <= ERR_CODE_RST;
            end else if (any_err) begin
               err_code_reg[g] <= code_sel;
            end
         end

         always_ff @(posedge clk_i) begin
            if (srst_i) begin
               err_stat_reg[g] <= 1'b0;
            end else begin
               // Errors bypass every mask
               err_stat_reg[g] <= (err_stat_reg[g] & ~(wr_err_stat & wdata_i[g]))
                                  | any_err;
            end
         end

         // Encoder and pulse input faults report without stopping the axis
         always_ff @(posedge clk_i) begin
            if (srst_i) begin
               axis_stop_reg[g] <= 1'b0;
            end else begin
               axis_stop_reg[g] <= stop_err;
            end
         end
      end
   endgenerate

   // ======================================================================
   // Group interrupt status, mask and request
   logic [IRQ_W-1:0] grp_evt;

   always_comb begin
      grp_evt = '0;
      grp_evt[IRQ_MOT_BIT] = |mot_pend;
      grp_evt[IRQ_IN_BIT]  = |in_stat_reg;
      grp_evt[IRQ_ERR_BIT] = |err_stat_reg;
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         irq_stat_reg <= '0;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~(wr_irq_stat ? wdata_i[IRQ_W-1:0] : '0))
                         | grp_evt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         irq_mask_reg <= IRQ_MASK_RST;
      end else if (wr_irq_mask) begin
         irq_mask_reg <= wdata_i[IRQ_W-1:0];
      end
   end

   // Error group cannot be masked off
   logic [IRQ_W-1:0] eff_mask;
   always_comb begin
      eff_mask = irq_mask_reg;
      eff_mask[IRQ_ERR_BIT] = 1'b1;
   end

   assign irq_o       = gie_reg && |(irq_stat_reg & eff_mask);
   assign axis_stop_o = axis_stop_reg;

   // ======================================================================
   // Read data, one cycle after the strobe
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rdata_reg <= 32'h0000_0000;
      end else if (rd_i) begin
         case (addr_i)
            ADDR_CTRL:       rdata_reg <= {31'h0, gie_reg};
            ADDR_MOT_MASK0:  rdata_reg <= mot_mask_reg[0];
            ADDR_MOT_MASK1:  rdata_reg <= mot_mask_reg[1];
            ADDR_IN_MASK:    rdata_reg <= {16'h0, in_mask_reg};
            ADDR_MOT_STAT0:  rdata_reg <= mot_stat_reg[0];
            ADDR_MOT_STAT1:  rdata_reg <= mot_stat_reg[1];
            ADDR_IN_STAT:    rdata_reg <= {16'h0, in_stat_reg};
            ADDR_ERR_STAT:   rdata_reg <= {30'h0, err_stat_reg};
            ADDR_ERR_CODE0:  rdata_reg <= {27'h0, err_code_reg[0]};
            ADDR_ERR_CODE1:  rdata_reg <= {27'h0, err_code_reg[1]};
            ADDR_IRQ_STATUS: rdata_reg <= {29'h0, irq_stat_reg};
            ADDR_IRQ_MASK:   rdata_reg <= {29'h0, irq_mask_reg};
            default:         rdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   assign rdata_o = rdata_reg;

endmodule

//--- dv/mcic_sva.sv
// Checker: port-level assertions for the interrupt control block
`timescale 1ns/1ps
module mcic_sva
   import mcic_pkg::*;
(
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 srst_i,
   // Register port
   input  wire logic [7:0]           addr_i,
   input  wire logic [31:0]          wdata_i,
   input  wire logic                 wr_i,
   input  wire logic                 rd_i,
   input  wire logic [31:0]          rdata_o,
   // Errors and outputs
   input  wire logic [ERR_SRC_W-1:0] error_event_ax0_i,
   input  wire logic [ERR_SRC_W-1:0] error_event_ax1_i,
   input  wire logic [NUM_AXES-1:0]  axis_stop_o,
   input  wire logic                 irq_o
);
   // ======================================================================
   // Shadow of the global enable
   logic gie_q;
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         gie_q <= 1'b0;
      end else if (wr_i && addr_i == ADDR_CTRL) begin
         gie_q <= wdata_i[CTRL_GIE_BIT];
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);

   // ======================================================================
   // Assertions
   chk_reset_quiet: assert property ($fell(srst_i) |->
      !irq_o && rdata_o == 32'h0 && axis_stop_o == 2'h0) else $error("outputs busy after reset");
   chk_gie_gate: assert property (!gie_q |-> !irq_o)
      else $error("request without global enable");
   chk_err_unmasked: assert property (gie_q && (error_event_ax0_i & ~18'h00800) != 0
      |-> ##[1:3] irq_o) else $error("error event gave no request");
   chk_stop_alarm: assert property (error_event_ax0_i[ERR_ALARM] |=> axis_stop_o[0])
      else $error("alarm did not stop axis 0");
   chk_stop_emerg: assert property (error_event_ax1_i[ERR_EMERGENCY] |=> axis_stop_o[1])
      else $error("emergency did not stop axis 1");
   chk_fault_nostop: assert property (!axis_stop_o[0] && error_event_ax0_i != 0 &&
      (error_event_ax0_i & ~ERR_NOSTOP_SRCS) == 0 |=> !axis_stop_o[0])
      else $error("signal fault stopped axis");
   chk_motmask_zero: assert property (rd_i && addr_i == ADDR_MOT_MASK0
      |=> (rdata_o & ~MOT_VALID_BITS) == 32'h0) else $error("unused motion mask bit set");
   chk_inmask_fixed: assert property (rd_i && addr_i == ADDR_IN_MASK
      |=> rdata_o[15] && rdata_o[14:11] == 4'h0) else $error("input mask fixed bits wrong");
   chk_rdata_hold: assert property (!rd_i |=> $stable(rdata_o))
      else $error("read data changed without read");

   cover property (gie_q && irq_o);
   cover property (axis_stop_o[0]);
   cover property (rd_i && addr_i == ADDR_IN_MASK);
endmodule

bind motion_card_interrupt_control mcic_sva chk_u (
   .clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .error_event_ax0_i(error_event_ax0_i),
   .error_event_ax1_i(error_event_ax1_i), .axis_stop_o(axis_stop_o), .irq_o(irq_o));

//--- dv/host_model.sv
// Host model: register port master
`timescale 1ns/1ps
module host_model (
   // Clock
   input  wire logic        clk_i,
   // Register port
   output logic      [7:0]  addr_o,
   output logic      [31:0] wdata_o,
   output logic             wr_o,
   output logic             rd_o,
   input  wire logic [31:0] rdata_i
);
   initial begin
      addr_o  = 8'h00;
      wdata_o = 32'h0;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_o  <= a;
      wdata_o <= d;
      wr_o    <= 1'b1;
      @(posedge clk_i);
      wr_o    <= 1'b0;
      wdata_o <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_i);
      addr_o <= a;
      rd_o   <= 1'b1;
      @(posedge clk_i);
      rd_o   <= 1'b0;
      #1 d = rdata_i;
   endtask
endmodule

//--- dv/testbench.sv
// Testbench: masks, events, error codes and request of the interrupt control block
`timescale 1ns/1ps
module testbench;
   import mcic_pkg::*;
   typedef struct packed {logic ax; logic [31:0] mask; logic [31:0] ev; logic [31:0] exp;} row_t;
   logic                 clk, srst, wr, rd, selx, sely, irq;
   logic [7:0]           addr;
   logic [31:0]          wdata, rdata, mev0, mev1;
   logic [ERR_SRC_W-1:0] eev0, eev1;
   logic [NUM_DIN-1:0]   din;
   logic [NUM_AXES-1:0]  stop;
   int                   err_total = 0;
   int                   tests_run = 0;
   row_t rows [5] = '{
      '{1'b0, 32'h0000_0001, 32'h0000_0001, 32'h0000_0001},
      '{1'b0, 32'h0000_0000, 32'hffff_ffff, 32'h0000_0000},
      '{1'b0, 32'hffff_ffff, 32'hffff_ffff, MOT_VALID_BITS},
      '{1'b1, 32'h0001_f0f7, 32'h0000_ff00, 32'h0000_f000},
      '{1'b1, 32'h0008_0000, 32'h0008_0000, 32'h0008_0000}};

   motion_card_interrupt_control dut_u (
      .clk_i(clk), .srst_i(srst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .motion_event_ax0_i(mev0), .motion_event_ax1_i(mev1),
      .error_event_ax0_i(eev0), .error_event_ax1_i(eev1), .digital_input_i(din),
      .selectable_input_x_i(selx), .selectable_input_y_i(sely), .axis_stop_o(stop),
      .irq_o(irq));
   host_model host_u (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
      .rdata_i(rdata));

   // ======================================================================
   // Helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      host_u.rd(a, d);
      check(d, exp);
   endtask
   task automatic stop_test();
      $display("Counts: %0d compared, %0d mismatched", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      #1_000_000;
      err_total++;
      stop_test();
   end

   // ======================================================================
   // Main sequence
   initial begin
      logic [7:0]  ma;
      srst = 1'b1;
      mev0 = '0;
      mev1 = '0;
      eev0 = '0;
      eev1 = '0;
      din  = 4'hf;
      selx = 1'b0;
      sely = 1'b0;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      host_u.wr(ADDR_CTRL, 32'h1);
      foreach (rows[i]) begin
         ma = rows[i].ax ? ADDR_MOT_MASK1 : ADDR_MOT_MASK0;
         host_u.wr(ma, rows[i].mask);
         rdchk(ma, rows[i].mask & MOT_VALID_BITS);
         @(posedge clk);
         if (rows[i].ax) mev1 <= rows[i].ev;
         else mev0 <= rows[i].ev;
         @(posedge clk);
         mev0 <= '0;
         mev1 <= '0;
         repeat (4) @(posedge clk);
         rdchk(ma + 8'h0c, rows[i].exp);
         check({31'h0, irq}, {31'h0, rows[i].exp != 32'h0});
         host_u.wr(ma + 8'h0c, 32'hffff_ffff);
         host_u.wr(ADDR_IRQ_STATUS, 32'h7);
         #1 check({31'h0, irq}, 32'h0);
      end
      $display("Test motion rows done");
      host_u.wr(ADDR_IRQ_MASK, 32'h0);
      for (int c = 17; c >= 0; c--) begin
         if (c == 11) continue;
         @(posedge clk);
         eev0 <= 18'h1 << c;
         @(posedge clk);
         eev0 <= '0;
         #1 check({31'h0, stop[0]}, {31'h0, c < 16});
         repeat (3) @(posedge clk);
         #1 check({31'h0, irq}, 32'h1);
         rdchk(ADDR_ERR_CODE0, 32'(c));
         host_u.wr(ADDR_ERR_STAT, 32'h3);
         host_u.wr(ADDR_IRQ_STATUS, 32'h7);
      end
      $display("Test error codes done");
      host_u.wr(ADDR_IRQ_MASK, 32'h7);
      host_u.wr(ADDR_IN_MASK, 32'h0000_0511);
      rdchk(ADDR_IN_MASK, 32'h0000_8511);
      @(posedge clk);
      din <= 4'h0;
      repeat (6) @(posedge clk);
      rdchk(ADDR_IN_STAT, 32'h0000_0001);
      @(posedge clk);
      din  <= 4'hf;
      selx <= 1'b1;
      sely <= 1'b1;
      repeat (6) @(posedge clk);
      rdchk(ADDR_IN_STAT, 32'h0000_0111);
      check({31'h0, irq}, 32'h1);
      host_u.wr(ADDR_IRQ_MASK, 32'h5);
      #1 check({31'h0, irq}, 32'h0);
      host_u.wr(ADDR_IN_STAT, 32'h0000_ffff);
      host_u.wr(ADDR_IN_MASK, 32'h0000_0200);
      @(posedge clk);
      selx <= 1'b0;
      sely <= 1'b0;
      repeat (6) @(posedge clk);
      rdchk(ADDR_IN_STAT, 32'h0000_0200);
      $display("Test card inputs done");
      @(posedge clk);
      eev1 <= 18'h1 << ERR_EMERGENCY;
      @(posedge clk);
      eev1 <= '0;
      #1 check({31'h0, stop[1]}, 32'h1);
      repeat (3) @(posedge clk);
      rdchk(ADDR_ERR_CODE1, 32'h9);
      rdchk(ADDR_ERR_CODE0, 32'h0);
      check({31'h0, irq}, 32'h1);
      host_u.wr(ADDR_CTRL, 32'h0);
      #1 check({31'h0, irq}, 32'h0);
      host_u.wr(ADDR_CTRL, 32'h1);
      #1 check({31'h0, irq}, 32'h1);
      $display("Test second axis done");
      @(posedge clk);
      srst <= 1'b1;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      rdchk(ADDR_CTRL, 32'h0);
      rdchk(ADDR_MOT_MASK0, MOT_MASK_RST);
      rdchk(ADDR_IN_MASK, 32'h0000_8000);
      rdchk(ADDR_IRQ_MASK, 32'h7);
      host_u.wr(8'h30, 32'hffff_ffff);
      rdchk(8'h30, 32'h0);
      check({30'h0, stop}, 32'h0);
      $display("Test reset done");
      stop_test();
   end
endmodule
